// ==== rtl/charge_sequencer.v ====
// li-ion charge sequencing state machine with safety timers
// assumes comparator inputs from pins; status outputs are open-drain
//
// Functional notes
// R01 - reset state clears timers, zero current, all indicators released
// R02 - enter reset on power-up, dropout or battery overvoltage; in fault, dropout and overvoltage are ignored
// R03 - leave reset to prequal once supply good and battery not too hot
// R04 - prequal requests tenth current, cc indicator low, 7.5 min timeout
// R05 - prequal to fast charge when above undervoltage and temp ok
// R06 - prequal timeout while undervoltage gives fault, fault output low
// R07 - fast charge requests set current, cc indicator low, 90 min
// R08 - regulation voltage reached moves fast charge to full charge
// R09 - fast charge timeout before regulation voltage gives fault
// R10 - full charge is cv, cv indicator low, cc released, 90 min
// R11 - full charge to top-off on low current flag or timeout
// R12 - top-off keeps cv, indicators released, 45 min then done
// R13 - done requests zero current; below recharge threshold back to reset
// R14 - temp out of window in charge phases pauses, freezes timers
// R15 - temp out of window in prequal suspends charge and timer
// R16 - reset goes straight to fault when battery too hot
// R17 - fault requests zero current, fault low, others released
// R18 - releasing power-down input enters reset, timers cleared
// R19 - fast timeout from bulk base; others from short base
// R20 - fault holds until power cycled or power-down pulled low
// R21 - power-down low stops charging, all status outputs released
// R22 - timeouts are prescaled tick counters with set terminal count
// R23 - open-drain indicators are output enables, enabled pulls low
`timescale 1ns/1ps
`include "charge_map.vh"

module charge_sequencer #(
    parameter TICK_CYCLES   = `TICK_CYCLES,
    parameter PREQUAL_TICKS = `PREQUAL_TICKS,
    parameter FAST_TICKS    = `FAST_TICKS,
    parameter FULL_TICKS    = `FULL_TICKS,
    parameter TOPOFF_TICKS  = `TOPOFF_TICKS
) (
    input  wire       i_core_clk,
    input  wire       i_rst_n,
    input  wire       i_power_down_request_n,
    input  wire       i_supply_good,
    input  wire       i_dropout,
    input  wire       i_overvoltage,
    input  wire       i_undervoltage,
    input  wire       i_regulation_reached,
    input  wire       i_current_below_full,
    input  wire       i_below_recharge,
    input  wire       i_temp_ok,
    input  wire       i_temp_hot,
    output reg  [1:0] o_charge_current_setpoint,
    output reg        o_charge_enable,
    output reg        o_constant_current_indicator_oe,
    output reg        o_constant_voltage_indicator_oe,
    output reg        o_fault_indicator_oe,
    output reg  [2:0] o_state
);

    localparam TW = 24;

    // ****************************************
    // pin input synchronisers
    // ****************************************
    localparam NIN = 10;
    wire [NIN-1:0] raw_in;
    wire [NIN-1:0] clean;

    assign raw_in = {i_power_down_request_n, i_supply_good, i_dropout,
                     i_overvoltage, i_undervoltage, i_regulation_reached,
                     i_current_below_full, i_below_recharge, i_temp_ok,
                     i_temp_hot};

    genvar g;
    generate
        for (g = 0; g < NIN; g = g + 1) begin : sync
            reg s1;
            reg s2;
            reg s3;
            reg v;
            always @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    v  <= 1'b0;
                end else begin
                    s1 <= raw_in[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        v <= s3;
                    end
                end
            end
            assign clean[g] = v;
        end
    endgenerate

    wire pd_n     = clean[9];
    wire sup_ok   = clean[8];
    wire dropout  = clean[7];
    wire over_v   = clean[6];
    wire under_v  = clean[5];
    wire reg_hit  = clean[4];
    wire low_cur  = clean[3];
    wire recharge = clean[2];
    wire temp_ok  = clean[1];
    wire temp_hot = clean[0];

    // ****************************************
    // state register
    // ****************************************
    reg  [2:0] state;
    reg  [2:0] next_state;
    reg  [2:0] resume_state;
    reg  [2:0] next_resume_state;
    reg        pd_n_d;

    wire pd_release = pd_n && !pd_n_d;

    // ****************************************
    // timers
    // ****************************************
    wire short_exp;
    wire bulk_exp;
    reg  short_clear;
    reg  bulk_clear;
    reg  short_run;
    reg  bulk_run;
    reg  [TW-1:0] short_term;
    reg  [2:0]    phase;

    // suspend keeps the terminal count of the phase it paused
    always @* begin
        phase = state;
        if (state == `ST_SUSPEND) begin
            phase = resume_state; // R14
        end
    end

    always @* begin
        short_term = PREQUAL_TICKS[TW-1:0];
        if (phase == `ST_FULL) begin
            short_term = FULL_TICKS[TW-1:0];
        end
        if (phase == `ST_TOPOFF) begin
            short_term = TOPOFF_TICKS[TW-1:0];
        end
    end

    always @* begin
        short_run   = (state == `ST_PREQUAL && temp_ok)
                      || state == `ST_FULL || state == `ST_TOPOFF; // R19
        bulk_run    = (state == `ST_FAST); // R19
        short_clear = (state == `ST_RESET)
                      || (state != next_state && state != `ST_SUSPEND
                          && (next_state == `ST_FULL
                              || next_state == `ST_TOPOFF)); // R01
        bulk_clear  = (state == `ST_RESET); // R01
    end

    phase_timer #(
        .PRESCALE (TICK_CYCLES),
        .WIDTH    (TW)
    ) short_phase_time_base ( // R22
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_clear    (short_clear),
        .i_run      (short_run), // R15
        .i_terminal (short_term),
        .o_expired  (short_exp)
    );

    phase_timer #(
        .PRESCALE (TICK_CYCLES),
        .WIDTH    (TW)
    ) bulk_phase_time_base ( // R22
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_clear    (bulk_clear),
        .i_run      (bulk_run),
        .i_terminal (FAST_TICKS[TW-1:0]),
        .o_expired  (bulk_exp)
    );

    // ****************************************
    // next state
    // ****************************************
    always @* begin
        next_state        = state;
        next_resume_state = resume_state;
        case (state)
            `ST_RESET: begin
                next_resume_state = `ST_RESET;
                if (temp_hot) begin
                    next_state = `ST_FAULT; // R16
                end else if (sup_ok) begin
                    next_state = `ST_PREQUAL; // R03
                end
            end
            `ST_PREQUAL: begin
                if (!under_v && temp_ok) begin
                    next_state = `ST_FAST; // R05
                end else if (short_exp && under_v) begin
                    next_state = `ST_FAULT; // R06
                end
            end
            `ST_FAST: begin
                if (!temp_ok) begin
                    next_state        = `ST_SUSPEND; // R14
                    next_resume_state = `ST_FAST;
                end else if (reg_hit) begin
                    next_state = `ST_FULL; // R08
                end else if (bulk_exp) begin
                    next_state = `ST_FAULT; // R09
                end
            end
            `ST_FULL: begin
                if (!temp_ok) begin
                    next_state        = `ST_SUSPEND; // R14
                    next_resume_state = `ST_FULL;
                end else if (low_cur || short_exp) begin
                    next_state = `ST_TOPOFF; // R11
                end
            end
            `ST_TOPOFF: begin
                if (!temp_ok) begin
                    next_state        = `ST_SUSPEND; // R14
                    next_resume_state = `ST_TOPOFF;
                end else if (short_exp) begin
                    next_state = `ST_DONE; // R12
                end
            end
            `ST_DONE: begin
                if (recharge) begin
                    next_state = `ST_RESET; // R13
                end
            end
            `ST_SUSPEND: begin
                if (temp_ok) begin
                    next_state = resume_state; // R14
                end
            end
            `ST_FAULT: begin
                next_state = `ST_FAULT; // R20
            end
            default: begin
                next_state = `ST_RESET;
            end
        endcase
        if (state != `ST_FAULT && (dropout || over_v)) begin
            next_state = `ST_RESET; // R02
        end
        if (!pd_n || pd_release) begin
            next_state = `ST_RESET; // R18
        end
    end

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state        <= `ST_RESET; // R02
            resume_state <= `ST_RESET;
            pd_n_d       <= 1'b0;
        end else begin
            state        <= next_state;
            resume_state <= next_resume_state;
            pd_n_d       <= pd_n;
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_charge_current_setpoint       <= `CUR_ZERO;
            o_charge_enable                 <= 1'b0;
            o_constant_current_indicator_oe <= 1'b0;
            o_constant_voltage_indicator_oe <= 1'b0;
            o_fault_indicator_oe            <= 1'b0;
            o_state                         <= `ST_RESET;
        end else begin
            o_state <= next_state;
            case (next_state)
                `ST_PREQUAL: begin
                    o_charge_current_setpoint <= `CUR_TENTH; // R04
                    o_charge_enable           <= temp_ok; // R15
                    o_constant_current_indicator_oe <= 1'b1; // R04
                    o_constant_voltage_indicator_oe <= 1'b0;
                    o_fault_indicator_oe            <= 1'b0;
                end
                `ST_FAST: begin
                    o_charge_current_setpoint <= `CUR_FULL; // R07
                    o_charge_enable           <= 1'b1;
                    o_constant_current_indicator_oe <= 1'b1; // R07
                    o_constant_voltage_indicator_oe <= 1'b0;
                    o_fault_indicator_oe            <= 1'b0;
                end
                `ST_FULL: begin
                    o_charge_current_setpoint <= `CUR_CV; // R10
                    o_charge_enable           <= 1'b1;
                    o_constant_current_indicator_oe <= 1'b0; // R10
                    o_constant_voltage_indicator_oe <= 1'b1; // R10
                    o_fault_indicator_oe            <= 1'b0;
                end
                `ST_TOPOFF: begin
                    o_charge_current_setpoint <= `CUR_CV; // R12
                    o_charge_enable           <= 1'b1;
                    o_constant_current_indicator_oe <= 1'b0; // R12
                    o_constant_voltage_indicator_oe <= 1'b0;
                    o_fault_indicator_oe            <= 1'b0;
                end
                `ST_SUSPEND: begin
                    o_charge_current_setpoint <= `CUR_ZERO; // R14
                    o_charge_enable           <= 1'b0; // R14
                end
                `ST_FAULT: begin
                    o_charge_current_setpoint <= `CUR_ZERO; // R17
                    o_charge_enable           <= 1'b0;
                    o_constant_current_indicator_oe <= 1'b0; // R17
                    o_constant_voltage_indicator_oe <= 1'b0;
                    o_fault_indicator_oe            <= 1'b1; // R23
                end
                default: begin
                    // reset and done: zero current, all released
                    o_charge_current_setpoint <= `CUR_ZERO; // R01
                    o_charge_enable           <= 1'b0; // R13
                    o_constant_current_indicator_oe <= 1'b0; // R01
                    o_constant_voltage_indicator_oe <= 1'b0;
                    o_fault_indicator_oe            <= 1'b0;
                end
            endcase
            if (!pd_n) begin
                o_charge_enable                 <= 1'b0; // R21
                o_charge_current_setpoint       <= `CUR_ZERO;
                o_constant_current_indicator_oe <= 1'b0; // R21
                o_constant_voltage_indicator_oe <= 1'b0;
                o_fault_indicator_oe            <= 1'b0;
            end
        end
    end

endmodule

// ==== shared/charge_map.vh ====
// charge sequencer constants: state codes, current codes, timer counts
// assumes a 20 MHz core clock; counts are prescaled ticks
`ifndef CHARGE_MAP_VH
`define CHARGE_MAP_VH

// ****************************************
// states
// ****************************************
`define ST_RESET     3'h0
`define ST_PREQUAL   3'h1
`define ST_FAST      3'h2
`define ST_FULL      3'h3
`define ST_TOPOFF    3'h4
`define ST_DONE      3'h5
`define ST_SUSPEND   3'h6
`define ST_FAULT     3'h7

// ****************************************
// charge current request codes
// ****************************************
`define CUR_ZERO     2'h0
`define CUR_TENTH    2'h1
`define CUR_FULL     2'h2
`define CUR_CV       2'h3

// ****************************************
// time base
// ****************************************
`define CLK_HZ       20000000
`define TICK_MS      1000
// one tick per millisecond
`define TICK_CYCLES  (`CLK_HZ / `TICK_MS)
// timeouts in minutes, prequal in tenths of a minute
`define PREQUAL_MIN_X10 75
`define FAST_MIN     90
`define FULL_MIN     90
`define TOPOFF_MIN   45
// timeouts in ticks
`define PREQUAL_TICKS (`PREQUAL_MIN_X10 * 60 * `TICK_MS / 10)
`define FAST_TICKS   (`FAST_MIN * 60 * `TICK_MS)
`define FULL_TICKS   (`FULL_MIN * 60 * `TICK_MS)
`define TOPOFF_TICKS (`TOPOFF_MIN * 60 * `TICK_MS)

`endif

// ==== rtl/phase_timer.v ====
// prescaled timeout counter standing in for a capacitor-set time base
// assumes synchronous controls from the same clock domain
`timescale 1ns/1ps

module phase_timer #(
    parameter PRESCALE = 20000,
    parameter WIDTH    = 24
) (
    input  wire             i_core_clk,
    input  wire             i_rst_n,
    input  wire             i_clear,
    input  wire             i_run,
    input  wire [WIDTH-1:0] i_terminal,
    output reg              o_expired
);

    // ****************************************
    // prescaler and tick counter
    // ****************************************
    reg [31:0]      pre;
    reg [WIDTH-1:0] ticks;
    wire            tick;

    assign tick = (pre == PRESCALE - 1);

    always @(posedge i_core_clk) begin
        if (!i_rst_n || i_clear) begin
            pre       <= 32'h0;
            ticks     <= {WIDTH{1'b0}};
            o_expired <= 1'b0;
        end else if (i_run) begin
            pre <= tick ? 32'h0 : pre + 32'h1;
            if (tick && !o_expired) begin
                ticks <= ticks + {{(WIDTH-1){1'b0}}, 1'b1};
            end
            o_expired <= (ticks >= i_terminal);
        end
    end

endmodule

// ==== testbench/charge_sequencer_props.sv ====
// port checker for the charge sequencer state and indicator outputs
// assumes a bind into charge_sequencer with one clock domain
`timescale 1ns/1ps
`include "charge_map.vh"
module charge_sequencer_props #(
    parameter TICK_CYCLES = 2,
    parameter FAST_TICKS  = 20
) (
    input wire       i_core_clk,
    input wire       i_rst_n,
    input wire       i_power_down_request_n,
    input wire [1:0] o_charge_current_setpoint,
    input wire       o_charge_enable,
    input wire       o_constant_current_indicator_oe,
    input wire       o_constant_voltage_indicator_oe,
    input wire       o_fault_indicator_oe,
    input wire [2:0] o_state
);
    // ****************************************
    // helper counters
    // ****************************************
    localparam int FAST_LO = (FAST_TICKS - 1) * TICK_CYCLES;
    wire [2:0] ind = {o_constant_current_indicator_oe,
                      o_constant_voltage_indicator_oe, o_fault_indicator_oe};
    wire [1:0] sp = o_charge_current_setpoint;
    wire       en = o_charge_enable;
    wire [2:0] st = o_state;
    int        fast_cnt;
    int        pd_hi;
    int        pd_lo;
    always @(posedge i_core_clk) begin
        if (!i_rst_n || st == `ST_RESET)
            fast_cnt <= 0;
        else if (st == `ST_FAST)
            fast_cnt <= fast_cnt + 1;
        pd_hi <= i_power_down_request_n ? (pd_hi < 15 ? pd_hi + 1 : 15) : 0;
        pd_lo <= !i_power_down_request_n ? (pd_lo < 15 ? pd_lo + 1 : 15) : 0;
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    reset_quiet_a: assert property (
        st == `ST_RESET |-> !en && sp == `CUR_ZERO && ind == 3'h0)
        else $error("reset state drives charge or indicators");
    prequal_drive_a: assert property (
        st == `ST_PREQUAL |-> sp == `CUR_TENTH && ind == 3'h4)
        else $error("prequal drive wrong");
    fast_drive_a: assert property (
        st == `ST_FAST |-> en && sp == `CUR_FULL && ind == 3'h4)
        else $error("fast charge drive wrong");
    full_drive_a: assert property (
        st == `ST_FULL |-> en && sp == `CUR_CV && ind == 3'h2)
        else $error("full charge drive wrong");
    fault_drive_a: assert property (
        st == `ST_FAULT |-> !en && sp == `CUR_ZERO && ind == 3'h1)
        else $error("fault drive wrong");
    suspend_entry_a: assert property (
        st != $past(st) && st == `ST_SUSPEND |-> !en && ind == $past(ind)
        && $past(st) inside {`ST_FAST, `ST_FULL, `ST_TOPOFF})
        else $error("suspend entry wrong");
    done_exit_a: assert property (
        st == `ST_DONE |-> !en && ind == 3'h0 ##1 st inside {`ST_DONE, `ST_RESET})
        else $error("done state wrong");
    fault_hold_a: assert property (
        st == `ST_FAULT && pd_hi == 15 |=> st == `ST_FAULT)
        else $error("fault left while power-down high");
    shutdown_quiet_a: assert property (
        pd_lo == 15 |-> st == `ST_RESET && !en && ind == 3'h0)
        else $error("power-down low not quiet");
    fast_time_a: assert property (
        $past(st) == `ST_FAST && st == `ST_FAULT |-> fast_cnt >= FAST_LO)
        else $error("fast charge timeout early");
endmodule
bind charge_sequencer charge_sequencer_props #(
    .TICK_CYCLES(TICK_CYCLES), .FAST_TICKS(FAST_TICKS)
) u_charge_sequencer_props (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_power_down_request_n(i_power_down_request_n),
    .o_charge_current_setpoint(o_charge_current_setpoint),
    .o_charge_enable(o_charge_enable),
    .o_constant_current_indicator_oe(o_constant_current_indicator_oe),
    .o_constant_voltage_indicator_oe(o_constant_voltage_indicator_oe),
    .o_fault_indicator_oe(o_fault_indicator_oe), .o_state(o_state)
);

// ==== testbench/pack_sense_model.sv ====
// comparator model of the pack, supply and thermistor sense points
// assumes levels in mV, mA and tenths of a degree set by the bench
`timescale 1ns/1ps
module pack_sense_model #(
    parameter GOOD = 4500,
    parameter UV   = 3000,
    parameter RCH  = 4000,
    parameter REG  = 4200,
    parameter OV   = 4500,
    parameter DROP = 100,
    parameter TAIL = 150,
    parameter COLD = 25,
    parameter HOT  = 475
) (
    input  wire        [15:0] i_in_mv,
    input  wire        [15:0] i_cell_mv,
    input  wire        [15:0] i_cur_ma,
    input  wire signed [15:0] i_temp_dc,
    output wire               o_supply_good,
    output wire               o_dropout,
    output wire               o_overvoltage,
    output wire               o_undervoltage,
    output wire               o_regulation_reached,
    output wire               o_current_below_full,
    output wire               o_below_recharge,
    output wire               o_temp_ok,
    output wire               o_temp_hot
);
    // ****************************************
    // comparators
    // ****************************************
    assign o_supply_good        = i_in_mv >= GOOD;
    assign o_dropout            = i_in_mv < i_cell_mv + DROP;
    assign o_overvoltage        = i_cell_mv > OV;
    assign o_undervoltage       = i_cell_mv <= UV;
    assign o_regulation_reached = i_cell_mv >= REG;
    assign o_current_below_full = i_cur_ma < TAIL;
    assign o_below_recharge     = i_cell_mv < RCH;
    assign o_temp_ok            = i_temp_dc >= COLD && i_temp_dc <= HOT;
    assign o_temp_hot           = i_temp_dc >= HOT;
endmodule

// ==== testbench/charge_sequencer_tb.sv ====
// self-checking bench for the charge sequencer
// assumes the pack sense model and the bound port checker
`timescale 1ns/1ps
`include "charge_map.vh"
module charge_sequencer_tb;
    // ****************************************
    // signals and instances
    // ****************************************
    localparam TK = 2;
    localparam PQ = 15;
    localparam FT = 20;
    localparam FL = 15;
    localparam TO = 12;
    reg               i_core_clk;
    reg               i_rst_n;
    reg               pd_n;
    reg        [15:0] in_mv;
    reg        [15:0] cell_mv;
    reg        [15:0] cur_ma;
    reg signed [15:0] temp_dc;
    wire              good, drop, ovr, undr, regd, tail, rchg, t_ok, t_hot;
    wire        [1:0] sp;
    wire              en, cc, cv, flt;
    wire        [2:0] state;
    wire        [8:0] out_vec = {state, sp, en, cc, cv, flt};
    reg         [8:0] last_vec;
    reg         [8:0] exp_q[$];
    reg         [8:0] msk_q[$];
    integer           bad_count, check_count, junk;
    pack_sense_model u_pack_sense_model (
        .i_in_mv(in_mv), .i_cell_mv(cell_mv), .i_cur_ma(cur_ma),
        .i_temp_dc(temp_dc), .o_supply_good(good), .o_dropout(drop),
        .o_overvoltage(ovr), .o_undervoltage(undr),
        .o_regulation_reached(regd), .o_current_below_full(tail),
        .o_below_recharge(rchg), .o_temp_ok(t_ok), .o_temp_hot(t_hot));
    charge_sequencer #(.TICK_CYCLES(TK), .PREQUAL_TICKS(PQ),
        .FAST_TICKS(FT), .FULL_TICKS(FL), .TOPOFF_TICKS(TO)
    ) u_charge_sequencer (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_power_down_request_n(pd_n), .i_supply_good(good),
        .i_dropout(drop), .i_overvoltage(ovr), .i_undervoltage(undr),
        .i_regulation_reached(regd), .i_current_below_full(tail),
        .i_below_recharge(rchg), .i_temp_ok(t_ok), .i_temp_hot(t_hot),
        .o_charge_current_setpoint(sp), .o_charge_enable(en),
        .o_constant_current_indicator_oe(cc),
        .o_constant_voltage_indicator_oe(cv),
        .o_fault_indicator_oe(flt), .o_state(state));
    // ****************************************
    // helpers
    // ****************************************
    function [8:0] vec_of(input [2:0] s);
        case (s)
            `ST_PREQUAL: vec_of = {s, `CUR_TENTH, 4'hC};
            `ST_FAST:    vec_of = {s, `CUR_FULL, 4'hC};
            `ST_FULL:    vec_of = {s, `CUR_CV, 4'hA};
            `ST_TOPOFF:  vec_of = {s, `CUR_CV, 4'h8};
            `ST_SUSPEND: vec_of = {s, `CUR_ZERO, 4'h4};
            `ST_FAULT:   vec_of = {s, `CUR_ZERO, 4'h1};
            default:     vec_of = {s, `CUR_ZERO, 4'h0};
        endcase
    endfunction
    function integer rnd(input integer n);
        rnd = $urandom % n;
    endfunction
    task report(input string msg);
        bad_count = bad_count + 1;
        $display("unexpected at %0t: %s", $time, msg);
    endtask
    task finish_test;
        if (bad_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task push_v(input [8:0] v, input [8:0] m);
        exp_q.push_back(v);
        msk_q.push_back(m);
    endtask
    task push(input [2:0] s);
        push_v(vec_of(s), 9'h1FF);
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge i_core_clk);
    endtask
    task wait_st(input [2:0] s, input integer bound);
        integer n;
        n = 0;
        while (state !== s && n < bound) begin
            @(negedge i_core_clk);
            n = n + 1;
        end
        if (state !== s) begin
            report("state not reached in time");
            finish_test;
        end
    endtask
    task compare_vec(input [8:0] v, input [8:0] m);
        check_count = check_count + 1;
        if ((out_vec & m) !== (v & m))
            report($sformatf("outputs %h expected %h", out_vec, v));
    endtask
    // ****************************************
    // clock, monitor and sequence
    // ****************************************
    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end
    always @(negedge i_core_clk) begin
        if (out_vec !== last_vec) begin
            if (exp_q.size() == 0)
                report("output change with none expected");
            else
                compare_vec(exp_q.pop_front(), msk_q.pop_front());
        end
        last_vec = out_vec;
    end
    initial begin
        bad_count = 0;
        check_count = 0;
        last_vec = 9'h000;
        i_rst_n = 1'b0;
        pd_n = 1'b1;
        in_mv = 16'h2EE0;
        cell_mv = 16'h09C4;
        cur_ma = 16'h03E8;
        temp_dc = 16'h00FA;
        junk = $urandom(5);
        cyc(12);
        i_rst_n = 1'b1;
        push(`ST_PREQUAL);
        wait_st(`ST_PREQUAL, 40);
        push_v({`ST_PREQUAL, `CUR_TENTH, 4'h4}, 9'h1FF);
        temp_dc = 16'(-50 - rnd(100));
        cyc(PQ * TK * 3);
        push(`ST_PREQUAL);
        temp_dc = 16'h00FA;
        cyc(6);
        push(`ST_FAST);
        cell_mv = 16'(3100 + rnd(800));
        wait_st(`ST_FAST, 40);
        push(`ST_SUSPEND);
        temp_dc = 16'(-50 - rnd(100));
        cyc(FT * TK * 2);
        push(`ST_FAST);
        temp_dc = 16'h00FA;
        wait_st(`ST_FAST, 40);
        push(`ST_FULL);
        cell_mv = 16'h1068;
        wait_st(`ST_FULL, 40);
        push(`ST_TOPOFF);
        wait_st(`ST_TOPOFF, FL * TK + 40);
        push(`ST_DONE);
        wait_st(`ST_DONE, TO * TK + 40);
        push(`ST_RESET);
        push(`ST_PREQUAL);
        push(`ST_FAST);
        cell_mv = 16'(3500 + rnd(400));
        wait_st(`ST_FAST, 40);
        push(`ST_FULL);
        cell_mv = 16'h1068;
        wait_st(`ST_FULL, 40);
        push(`ST_TOPOFF);
        cur_ma = 16'(rnd(150));
        wait_st(`ST_TOPOFF, 40);
        push(`ST_RESET);
        in_mv = cell_mv + 16'h0032;
        cyc(10);
        push(`ST_PREQUAL);
        push(`ST_FAST);
        cell_mv = 16'h0DAC;
        in_mv = 16'h2EE0;
        cur_ma = 16'h03E8;
        wait_st(`ST_FAST, 40);
        push(`ST_FAULT);
        wait_st(`ST_FAULT, FT * TK + 40);
        cell_mv = 16'h11F8;
        cyc(12);
        cell_mv = 16'h09C4;
        push(`ST_RESET);
        pd_n = 1'b0;
        wait_st(`ST_RESET, 40);
        cyc(12);
        push(`ST_PREQUAL);
        pd_n = 1'b1;
        wait_st(`ST_PREQUAL, 40);
        push(`ST_FAULT);
        wait_st(`ST_FAULT, PQ * TK + 40);
        push(`ST_RESET);
        pd_n = 1'b0;
        temp_dc = 16'h0258;
        cyc(20);
        push(`ST_FAULT);
        pd_n = 1'b1;
        wait_st(`ST_FAULT, 40);
        cyc(12);
        if (exp_q.size() != 0)
            report("expected change never seen");
        finish_test;
    end
endmodule
